// [design/fieldbus_regs.svh]
// object indices, subindices, bit positions and reset values
// assumes: included by bare name from design modules and the bench
`ifndef FIELDBUS_REGS_SVH
`define FIELDBUS_REGS_SVH

// ----------------------------------------------------------------
// object indices
// ----------------------------------------------------------------
`define OD_IDX_AVAIL     16'h2101
`define OD_IDX_FB_CTRL   16'h2102
`define OD_IDX_FB_STATUS 16'h2103
`define OD_IDX_PROG_CTRL 16'h2300

// ----------------------------------------------------------------
// subindices of the status array
// ----------------------------------------------------------------
`define OD_SUB_TOP       8'h00
`define OD_SUB_SWMASK    8'h01
`define OD_SUB_ACTIVE    8'h02
`define OD_STATUS_TOPSUB 8'h02

// ----------------------------------------------------------------
// interface word layout: physical low half, protocol high half
// ----------------------------------------------------------------
`define FB_BIT_USB           0
`define FB_BIT_RS485         1
`define FB_BIT_RS232         2
`define FB_BIT_CAN           3
`define FB_BIT_ETHERNET_PORT 4
`define FB_BIT_INDUSTRIAL_ETH 5
`define FB_BIT_SPI           6
`define FB_BIT_SERIAL_MODBUS 16
`define FB_BIT_TCP_MODBUS    17
`define FB_BIT_INDUSTRIAL_IP 18
`define FB_PHYS_USED         32'h0000_007f
`define FB_PROTO_USED        32'h0007_0000

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FB_RST_AVAIL   32'h0002_0010
`define FB_RST_CTRL    32'h0002_0010
`define FB_RST_SWMASK  32'h0000_0000
`define FB_RST_ACTIVE  32'h0002_0010
`define PROG_RST_CTRL  32'h0000_0000
`define PROG_RUN_BIT   0

`endif

// [design/fieldbus_pkg.sv]
// types shared by the fieldbus select and program control block
// assumes: nothing beyond a SystemVerilog compiler
package fieldbus_pkg;

  // one object access from the fieldbus stack
  typedef struct packed {
    logic        write;     // 1 write, 0 read
    logic [15:0] index;     // object index
    logic [7:0]  subindex;  // object subindex
    logic [31:0] wdata;     // write value
  } od_req_s;

  // answer to an object access
  typedef struct packed {
    logic        ack;       // one-cycle answer strobe
    logic        err;       // unmapped target or write to read-only
    logic [31:0] rdata;     // read value, zero on writes
  } od_rsp_s;

  // user program launch sequence, one-hot
  typedef enum logic [3:0] {
    L_IDLE  = 4'b0001,
    L_LOAD  = 4'b0010,
    L_CLEAR = 4'b0100,
    L_RUN   = 4'b1000
  } launch_state_e;

endpackage : fieldbus_pkg

// [design/program_launch.sv]
// user program launch sequencer: reload, clear variables, then run
// assumes: done inputs come from loader logic on core_clk
`timescale 1ns/1ps
`include "fieldbus_regs.svh"

module program_launch
  import fieldbus_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // run bit from the program control register
  input  wire logic run_bit,
  // loader handshake
  input  wire logic load_done,
  input  wire logic clear_done,
  // sequencer outputs, all registered
  output logic      reload_req_r,
  output logic      var_clear_r,
  output logic      prog_run_r
);

  launch_state_e state_r;       // current step
  launch_state_e state_nxt;     // next step
  logic          run_prev_r;    // run bit one cycle ago
  logic          rise;          // zero-to-one of the run bit

  // ----------------------------------------------------------------
  // edge detect
  // ----------------------------------------------------------------
  assign rise = run_bit && !run_prev_r;

  // previous run bit
  always_ff @(posedge core_clk)
  begin
    if (reset)
      run_prev_r <= 1'b0;
    else
      run_prev_r <= run_bit;
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  // a cleared run bit aborts any step, so a stop always wins
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      L_IDLE:  if (rise) state_nxt = L_LOAD;
      L_LOAD:  if (!run_bit) state_nxt = L_IDLE;
               else if (load_done) state_nxt = L_CLEAR;
      L_CLEAR: if (!run_bit) state_nxt = L_IDLE;
               else if (clear_done) state_nxt = L_RUN;
      L_RUN:   if (!run_bit) state_nxt = L_IDLE;
      default: state_nxt = L_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (reset)
      state_r <= L_IDLE;
    else
      state_r <= state_nxt;
  end

  // outputs follow the next state so they line up with state_r
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      reload_req_r <= 1'b0;
      var_clear_r  <= 1'b0;
      prog_run_r   <= 1'b0;
    end
    else
    begin
      reload_req_r <= (state_nxt == L_LOAD);
      var_clear_r  <= (state_nxt == L_CLEAR);
      prog_run_r   <= (state_nxt == L_RUN);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  edge_starts_load_a: assert property ((state_r == L_IDLE) && rise |=> reload_req_r)
    else $error("rising run bit did not start reload");
  run_after_clear_a: assert property ($rose(prog_run_r) |-> $past(var_clear_r))
    else $error("program ran without clearing variables");
  stop_ends_run_a: assert property (!run_bit |=> !prog_run_r)
    else $error("program kept running after stop");

endmodule : program_launch

// [design/fieldbus_select_and_program_control.sv]
// fieldbus interface selection objects and user program control
// assumes: object accesses arrive from the fieldbus stack on core_clk
//
// Function
// - low half physical, high half protocol
// - physical bits: usb to spi, 0 to 6
// - protocol bits 16 to 18, rest zero
// - availability word read-only, existing interfaces set
// - availability reads 0x00020010
// - control writes change only switchable bits
// - control read/write, same layout, resets 0x00020010
// - switchable mask read-only, resets zero
// - active set read-only, resets 0x00020010
// - status subindex zero reads 2
// - program bit 0 runs or stops program
// - rising bit 0 reloads and clears first
`timescale 1ns/1ps
`include "fieldbus_regs.svh"

module fieldbus_select_and_program_control
  import fieldbus_pkg::*;
#(
  parameter logic [31:0] AVAIL_BITS  = `FB_RST_AVAIL,  // variant fit
  parameter logic [31:0] SWITCH_MASK = `FB_RST_SWMASK  // switchable set
)
(
  // clock and reset
  input  wire logic    core_clk,
  input  wire logic    reset,
  // object access from the fieldbus stack
  input  wire logic    od_valid,
  input  wire od_req_s od_req,
  output od_rsp_s      od_rsp_r,
  // interface enables toward the comms subsystem
  output logic [31:0]  fb_active_r,
  // user program loader handshake
  input  wire logic    load_done,
  input  wire logic    clear_done,
  output logic         reload_req_r,
  output logic         var_clear_r,
  output logic         prog_run_r
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  // all defined bit positions, both halves
  localparam logic [31:0] USED_BITS = `FB_PHYS_USED | `FB_PROTO_USED;
  // variant fit, trimmed to defined positions
  localparam logic [31:0] AVAIL_C = AVAIL_BITS & USED_BITS;
  // switchable set, only for what exists
  localparam logic [31:0] SWMASK_C = SWITCH_MASK & AVAIL_C;
  // program control: only bit 0 exists
  localparam logic [31:0] PROG_USED = 32'h0000_0001 << `PROG_RUN_BIT;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0] fb_ctrl_r;      // activation control word
  logic [31:0] fb_ctrl_nxt;    // its next value on a write
  logic [31:0] prog_ctrl_r;    // program control word
  logic        wr_fb_ctrl;     // accepted write to activation control
  logic        wr_prog_ctrl;   // accepted write to program control
  logic        hit;            // access names a mapped entry
  logic        ro_hit;         // mapped entry is read-only
  logic [31:0] rd_val;         // read value of the addressed entry

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // merge new bits under a mask, keep the rest
  function automatic logic [31:0] merge_masked(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [31:0] mask
  );
    merge_masked = (old_v & ~mask) | (new_v & mask);
  endfunction : merge_masked

  // true when the access targets a plain variable object
  function automatic logic var_obj(
    input od_req_s    r,
    input logic [15:0] idx
  );
    var_obj = (r.index == idx) && (r.subindex == `OD_SUB_TOP);
  endfunction : var_obj

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // every access is decoded here once; unmapped targets answer err
  always_comb
  begin
    hit    = 1'b0;
    ro_hit = 1'b0;
    rd_val = 32'h0000_0000;
    if (var_obj(od_req, `OD_IDX_AVAIL))
    begin
      hit    = 1'b1;
      ro_hit = 1'b1;
      rd_val = AVAIL_C;
    end
    else if (var_obj(od_req, `OD_IDX_FB_CTRL))
    begin
      hit    = 1'b1;
      rd_val = fb_ctrl_r;
    end
    else if (od_req.index == `OD_IDX_FB_STATUS)
    begin
      // the whole array is read-only
      ro_hit = 1'b1;
      if (od_req.subindex == `OD_SUB_TOP)
      begin
        hit    = 1'b1;
        rd_val = {24'h00_0000, `OD_STATUS_TOPSUB};
      end
      else if (od_req.subindex == `OD_SUB_SWMASK)
      begin
        hit    = 1'b1;
        rd_val = SWMASK_C;
      end
      else if (od_req.subindex == `OD_SUB_ACTIVE)
      begin
        hit    = 1'b1;
        rd_val = fb_active_r;
      end
    end
    else if (var_obj(od_req, `OD_IDX_PROG_CTRL))
    begin
      hit    = 1'b1;
      rd_val = prog_ctrl_r;
    end
  end

  // write strobes only for writable, mapped entries
  assign wr_fb_ctrl   = od_valid && od_req.write &&
                        var_obj(od_req, `OD_IDX_FB_CTRL);
  assign wr_prog_ctrl = od_valid && od_req.write &&
                        var_obj(od_req, `OD_IDX_PROG_CTRL);

  // ----------------------------------------------------------------
  // activation control
  // ----------------------------------------------------------------
  // only switchable bits move; with the default empty mask the word
  // is fixed, which is how a variant locks its only interface
  assign fb_ctrl_nxt = merge_masked(fb_ctrl_r, od_req.wdata, SWMASK_C);

  // control word register
  always_ff @(posedge core_clk)
  begin
    if (reset)
      fb_ctrl_r <= `FB_RST_CTRL;
    else if (wr_fb_ctrl)
      fb_ctrl_r <= fb_ctrl_nxt & USED_BITS;
  end

  // active set: what is requested and actually fitted
  always_ff @(posedge core_clk)
  begin
    if (reset)
      fb_active_r <= `FB_RST_ACTIVE;
    else
      fb_active_r <= fb_ctrl_r & AVAIL_C;
  end

  // ----------------------------------------------------------------
  // program control
  // ----------------------------------------------------------------
  // undefined bits are dropped so they always read zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
      prog_ctrl_r <= `PROG_RST_CTRL;
    else if (wr_prog_ctrl)
      prog_ctrl_r <= od_req.wdata & PROG_USED;
  end

  // launch sequencer sees the stored bit, edge found inside
  program_launch u_launch (
    .core_clk     (core_clk),
    .reset        (reset),
    .run_bit      (prog_ctrl_r[`PROG_RUN_BIT]),
    .load_done    (load_done),
    .clear_done   (clear_done),
    .reload_req_r (reload_req_r),
    .var_clear_r  (var_clear_r),
    .prog_run_r   (prog_run_r)
  );

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  // one answer per access, one cycle later; writes to read-only
  // entries and unmapped targets answer err and change nothing
  always_ff @(posedge core_clk)
  begin
    if (reset)
      od_rsp_r <= '0;
    else
    begin
      od_rsp_r.ack   <= od_valid;
      od_rsp_r.err   <= od_valid && (!hit || (od_req.write && ro_hit));
      od_rsp_r.rdata <= (od_valid && hit && !od_req.write) ?
                        rd_val : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic [31:0] fixed_bits;   // control bits that writes may not move
  assign fixed_bits = fb_ctrl_r & ~SWMASK_C;

  avail_read_value_a: assert property (
    od_valid && !od_req.write && var_obj(od_req, `OD_IDX_AVAIL)
    |=> od_rsp_r.ack && !od_rsp_r.err && od_rsp_r.rdata == AVAIL_C)
    else $error("availability read returned wrong value");

  avail_write_err_a: assert property (
    od_valid && od_req.write && var_obj(od_req, `OD_IDX_AVAIL)
    |=> od_rsp_r.err)
    else $error("write to availability not refused");

  ctrl_fixed_bits_a: assert property (
    wr_fb_ctrl |=> fixed_bits == $past(fixed_bits))
    else $error("write moved a non-switchable control bit");

  ctrl_readback_a: assert property (
    od_valid && !od_req.write && var_obj(od_req, `OD_IDX_FB_CTRL)
    |=> od_rsp_r.rdata == $past(fb_ctrl_r))
    else $error("control read differs from stored word");

  mask_read_value_a: assert property (
    od_valid && !od_req.write && od_req.index == `OD_IDX_FB_STATUS &&
    od_req.subindex == `OD_SUB_SWMASK |=> od_rsp_r.rdata == SWMASK_C)
    else $error("switchable mask read wrong");

  active_follows_ctrl_a: assert property (
    ##1 fb_active_r == ($past(fb_ctrl_r) & AVAIL_C))
    else $error("active set does not track control");

  top_subindex_a: assert property (
    od_valid && !od_req.write && od_req.index == `OD_IDX_FB_STATUS &&
    od_req.subindex == `OD_SUB_TOP |=> od_rsp_r.rdata == 32'h0000_0002)
    else $error("highest subindex not two");

  unused_bits_zero_a: assert property (
    (fb_ctrl_r & ~USED_BITS) == 32'h0000_0000 &&
    (prog_ctrl_r & ~PROG_USED) == 32'h0000_0000)
    else $error("unused control bit set");

  layout_halves_a: assert property (
    (fb_active_r & ~USED_BITS) == 32'h0000_0000)
    else $error("active set outside defined positions");

  run_needs_reload_a: assert property (
    $rose(prog_ctrl_r[`PROG_RUN_BIT]) |=> reload_req_r)
    else $error("rising run bit did not reload program");

  run_stops_a: assert property (
    !prog_ctrl_r[`PROG_RUN_BIT] |=> !prog_run_r)
    else $error("program not stopped by cleared bit");

  cov_ctrl_write_c:  cover property (wr_fb_ctrl);
  cov_bad_access_c:  cover property (od_rsp_r.ack && od_rsp_r.err);
  cov_program_run_c: cover property ($rose(prog_run_r));
  cov_abort_load_c:  cover property (reload_req_r ##1 !reload_req_r && !var_clear_r);

endmodule : fieldbus_select_and_program_control

// [tb/tb_top.sv]
// self-checking bench for the fieldbus select and program control block
// assumes: design package and header compiled first, one clock core_clk
`timescale 1ns/1ps
`include "fieldbus_regs.svh"

module tb_top
  import fieldbus_pkg::*;
;

  // ----------------------------------------------------------------
  // signals and models
  // ----------------------------------------------------------------
  // nonzero so that control writes really move bits; kept inside avail
  localparam logic [31:0] SW_MASK = 32'h0002_0010;
  localparam logic [31:0] AVAIL   = `FB_RST_AVAIL;

  logic        core_clk;      // 125 MHz
  logic        reset;         // sync, active high
  logic        od_valid;      // access strobe
  od_req_s     od_req;        // access payload
  od_rsp_s     od_rsp_r;      // access answer
  logic [31:0] fb_active_r;   // active set
  logic        load_done;     // loader handshake
  logic        clear_done;    // clear handshake
  logic        reload_req_r;  // launch outputs
  logic        var_clear_r;
  logic        prog_run_r;
  int          err_count;     // mismatches
  int          checks;        // comparisons
  logic [31:0] ctrl_m;        // control word model
  logic [31:0] wd;            // stimulus word

  fieldbus_select_and_program_control #(
    .AVAIL_BITS  (AVAIL),
    .SWITCH_MASK (SW_MASK)
  ) dut (
    .core_clk     (core_clk),
    .reset        (reset),
    .od_valid     (od_valid),
    .od_req       (od_req),
    .od_rsp_r     (od_rsp_r),
    .fb_active_r  (fb_active_r),
    .load_done    (load_done),
    .clear_done   (clear_done),
    .reload_req_r (reload_req_r),
    .var_clear_r  (var_clear_r),
    .prog_run_r   (prog_run_r)
  );

  // free-running clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // control update: only switchable bits follow the write
  function automatic logic [31:0] ctrl_next(input logic [31:0] old_w,
                                            input logic [31:0] new_w);
    ctrl_next = (old_w & ~SW_MASK) | (new_w & SW_MASK);
  endfunction : ctrl_next

  // verdict, the single exit of the run
  task automatic results;
    $display("errors %0d, checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // one comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // launch outputs packed as run, clear, reload
  task automatic chk_launch(input logic [2:0] exp);
    chk({29'h0, prog_run_r, var_clear_r, reload_req_r}, {29'h0, exp});
  endtask : chk_launch

  // one object access; answer sampled just after the taking edge,
  // since it stands for that one cycle only
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wdv, input logic e, input logic [31:0] rd);
    @(posedge core_clk);
    #1;
    od_valid = 1'b1;
    od_req   = '{write: w, index: idx, subindex: sub, wdata: wdv};
    @(posedge core_clk);
    #1;
    od_valid = 1'b0;
    od_req   = ~od_req;  // stale payload must not matter
    chk({31'h0, od_rsp_r.ack}, 32'h1);
    chk({31'h0, od_rsp_r.err}, {31'h0, e});
    chk(od_rsp_r.rdata, rd);
    @(posedge core_clk);
    #1;
    // the answer must be gone one cycle later
    chk({31'h0, od_rsp_r.ack}, 32'h0);
  endtask : acc

  // bounded wait for one launch output to reach a level
  task automatic wait_bit(input int sel, input logic lvl);
    logic [2:0] l;
    int         n;
    n = 0;
    l = {prog_run_r, var_clear_r, reload_req_r};
    while (l[sel] !== lvl && n < 8)
    begin
      @(posedge core_clk);
      #1;
      n++;
      l = {prog_run_r, var_clear_r, reload_req_r};
    end
    if (l[sel] !== lvl)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, l[sel], lvl);
      results();
    end
  endtask : wait_bit

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset      = 1'b1;
    od_valid   = 1'b0;
    od_req     = '0;
    load_done  = 1'b0;
    clear_done = 1'b0;
    err_count  = 0;
    checks     = 0;
    ctrl_m     = `FB_RST_CTRL;
    wd         = $urandom(32'hb74b);
    repeat (8) @(posedge core_clk);
    #1;
    reset = 1'b0;

    // reset values through the object bus
    chk(fb_active_r, `FB_RST_ACTIVE);
    chk_launch(3'b000);
    acc(1'b0, `OD_IDX_AVAIL, 8'h00, 32'h0, 1'b0, AVAIL);
    acc(1'b0, `OD_IDX_FB_CTRL, 8'h00, 32'h0, 1'b0, ctrl_m);
    acc(1'b0, `OD_IDX_FB_STATUS, 8'h00, 32'h0, 1'b0, 32'h2);
    acc(1'b0, `OD_IDX_FB_STATUS, 8'h01, 32'h0, 1'b0, SW_MASK);
    acc(1'b0, `OD_IDX_FB_STATUS, 8'h02, 32'h0, 1'b0, AVAIL);
    acc(1'b0, `OD_IDX_PROG_CTRL, 8'h00, 32'h0, 1'b0, 32'h0);

    // read-only and unmapped targets refuse and keep their value
    acc(1'b1, `OD_IDX_AVAIL, 8'h00, 32'hffff_ffff, 1'b1, 32'h0);
    acc(1'b1, `OD_IDX_FB_STATUS, 8'h01, 32'hffff_ffff, 1'b1, 32'h0);
    acc(1'b1, `OD_IDX_FB_STATUS, 8'h02, 32'h0, 1'b1, 32'h0);
    acc(1'b0, 16'h2104, 8'h00, 32'h0, 1'b1, 32'h0);
    acc(1'b1, `OD_IDX_FB_CTRL, 8'h01, 32'h0, 1'b1, 32'h0);
    acc(1'b0, `OD_IDX_AVAIL, 8'h00, 32'h0, 1'b0, AVAIL);
    acc(1'b0, `OD_IDX_FB_STATUS, 8'h01, 32'h0, 1'b0, SW_MASK);

    // control writes: corners first, then random words
    for (int i = 0; i < 24; i++)
    begin
      wd = (i == 0) ? 32'h0 : (i == 1) ? 32'hffff_ffff : $urandom;
      acc(1'b1, `OD_IDX_FB_CTRL, 8'h00, wd, 1'b0, 32'h0);
      ctrl_m = ctrl_next(ctrl_m, wd);
      acc(1'b0, `OD_IDX_FB_CTRL, 8'h00, 32'h0, 1'b0, ctrl_m);
      chk(fb_active_r, ctrl_m & AVAIL);
      acc(1'b0, `OD_IDX_FB_STATUS, 8'h02, 32'h0, 1'b0, ctrl_m & AVAIL);
    end

    // full launch: reload, clear, then run
    acc(1'b1, `OD_IDX_PROG_CTRL, 8'h00, 32'hffff_ffff, 1'b0, 32'h0);
    @(posedge core_clk);
    #1;
    chk_launch(3'b001);
    repeat ($urandom_range(0, 5)) @(posedge core_clk);
    #1;
    chk_launch(3'b001);
    load_done = 1'b1;
    wait_bit(1, 1'b1);
    load_done = 1'b0;
    chk_launch(3'b010);
    repeat ($urandom_range(0, 5)) @(posedge core_clk);
    #1;
    clear_done = 1'b1;
    wait_bit(2, 1'b1);
    clear_done = 1'b0;
    chk_launch(3'b100);
    acc(1'b0, `OD_IDX_PROG_CTRL, 8'h00, 32'h0, 1'b0, 32'h1);

    // stop while running
    acc(1'b1, `OD_IDX_PROG_CTRL, 8'h00, 32'hffff_fffe, 1'b0, 32'h0);
    @(posedge core_clk);
    #1;
    chk_launch(3'b000);

    // abort in mid reload, then no relaunch while bit stays low
    acc(1'b1, `OD_IDX_PROG_CTRL, 8'h00, 32'h1, 1'b0, 32'h0);
    @(posedge core_clk);
    #1;
    chk_launch(3'b001);
    acc(1'b1, `OD_IDX_PROG_CTRL, 8'h00, 32'h0, 1'b0, 32'h0);
    @(posedge core_clk);
    #1;
    chk_launch(3'b000);
    load_done  = 1'b1;
    clear_done = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk_launch(3'b000);
    load_done  = 1'b0;
    clear_done = 1'b0;
    acc(1'b0, `OD_IDX_PROG_CTRL, 8'h00, 32'h0, 1'b0, 32'h0);
    results();
  end

endmodule : tb_top
